// [shared/rotate_right_pkg.sv]
package rotate_right_pkg;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] BIT_OP_PREFIX = 8'hcb;
  localparam logic [4:0] ROTATE_RIGHT_CARRY_OP = 5'h03;
  localparam logic [2:0] MEM_REG_SELECT = 3'h6;
  localparam logic [1:0] INDEX_PREFIX_HI = 2'h3;
  localparam logic [4:0] INDEX_PREFIX_LO = 5'h1d;
  localparam int OP_FIELD_HI = 7;
  localparam int OP_FIELD_LO = 3;
  localparam int REG_FIELD_HI = 2;
  localparam int REG_FIELD_LO = 0;
  localparam int PREFIX_HI_HI = 7;
  localparam int PREFIX_HI_LO = 6;
  localparam int PREFIX_LO_HI = 4;
  localparam int PREFIX_SEL_BIT = 5;

  // ----------------------------------------------------------------
  // flag byte layout
  // ----------------------------------------------------------------
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_HALF = 4;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_SUB = 1;
  localparam int FLAG_CARRY = 0;
  localparam int MSB = 7;
  localparam int LSB = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [2:0] REG_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // operand modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    register_mode,
    indirect_register_mode,
    short_indexed_mode
  } operand_mode_t;

  typedef enum logic [2:0] {
    st_idle,
    st_bit_prefix,
    st_index_prefix,
    st_index_bit_prefix,
    st_displacement,
    st_wait_operand
  } decode_state_t;

endpackage

// [verilog/rr_flag_calc.sv]
`timescale 1ns/100ps
module rr_flag_calc (
  input wire logic [7:0] operand_i,
  input wire logic carry_i,
  input wire logic [7:0] flags_i,
  output logic [7:0] result_o,
  output logic [7:0] flags_o
);

  // ----------------------------------------------------------------
  // rotation and flags, purely combinational
  // ----------------------------------------------------------------
  logic [7:0] res;

  always_comb begin
    // carry goes in on top, every other bit moves down one place
    res = {carry_i, operand_i[rotate_right_pkg::MSB:
                              rotate_right_pkg::LSB + 1]}; // RULE1 RULE2
    result_o = res;
    // undefined flag bits pass through untouched
    flags_o = flags_i;
    flags_o[rotate_right_pkg::FLAG_SIGN] = res[rotate_right_pkg::MSB]; // RULE4
    flags_o[rotate_right_pkg::FLAG_ZERO] = (res == rotate_right_pkg::BYTE_ZERO); // RULE5
    flags_o[rotate_right_pkg::FLAG_PARITY] = ~(^res); // RULE6
    flags_o[rotate_right_pkg::FLAG_HALF] = 1'b0; // RULE9
    flags_o[rotate_right_pkg::FLAG_SUB] = 1'b0; // RULE9
    flags_o[rotate_right_pkg::FLAG_CARRY] = operand_i[rotate_right_pkg::LSB]; // RULE3
  end

endmodule

// [verilog/rotate_right_carry_unit.sv]
// How it works
// RULE1 - bits zero to six take next higher bit
// RULE2 - old carry goes into result bit 7
// RULE3 - carry takes original operand bit 0
// RULE4 - sign follows result bit 7
// RULE5 - zero set when result is all zero
// RULE6 - parity set when one count is even
// RULE7 - decode bit prefix then register rotate byte
// RULE8 - register field 110 means pointer pair memory
// RULE9 - half carry and subtract always cleared
// RULE10 - index prefix, select bit, signed displacement address
`timescale 1ns/100ps
module rotate_right_carry_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] pointer_register_pair_i,
  input wire logic [15:0] first_index_register_i,
  input wire logic [15:0] second_index_register_i,
  input wire logic operand_valid_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] flags_i,
  output logic byte_ready_o,
  output logic decoded_o,
  output logic decode_error_o,
  output rotate_right_pkg::operand_mode_t mode_o,
  output logic [2:0] reg_select_o,
  output logic index_select_o,
  output logic [15:0] operand_addr_o,
  output logic result_valid_o,
  output logic [7:0] result_o,
  output logic [7:0] flags_o
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    rotate_right_pkg::decode_state_t st;
    rotate_right_pkg::operand_mode_t mode;
    logic [2:0] reg_sel;
    logic idx_sel;
    logic [15:0] addr;
    logic byte_ready;
    logic decoded;
    logic decode_error;
    logic result_valid;
    logic [7:0] result;
    logic [7:0] flags;
  } unit_state_t;

  unit_state_t state_reg;
  unit_state_t state_next;

  logic [7:0] calc_result;
  logic [7:0] calc_flags;
  logic [15:0] index_base;
  logic [15:0] disp_ext;
  logic is_rotate_byte;
  logic is_index_prefix;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // carry in is the flag held before this instruction
  rr_flag_calc u_calc (
    .operand_i(operand_i),
    .carry_i(flags_i[rotate_right_pkg::FLAG_CARRY]),
    .flags_i(flags_i),
    .result_o(calc_result),
    .flags_o(calc_flags)
  );

  // ----------------------------------------------------------------
  // byte classification
  // ----------------------------------------------------------------
  always_comb begin
    is_rotate_byte = (byte_i[rotate_right_pkg::OP_FIELD_HI:
                             rotate_right_pkg::OP_FIELD_LO]
                      == rotate_right_pkg::ROTATE_RIGHT_CARRY_OP); // RULE7
    is_index_prefix = (byte_i[rotate_right_pkg::PREFIX_HI_HI:
                              rotate_right_pkg::PREFIX_HI_LO]
                       == rotate_right_pkg::INDEX_PREFIX_HI)
                      && (byte_i[rotate_right_pkg::PREFIX_LO_HI:
                                 rotate_right_pkg::LSB]
                          == rotate_right_pkg::INDEX_PREFIX_LO); // RULE10
    // index registers are read only as the displacement arrives
    index_base = state_reg.idx_sel ? second_index_register_i
                                   : first_index_register_i; // RULE10
    disp_ext = {{8{byte_i[rotate_right_pkg::MSB]}}, byte_i}; // RULE10
  end

  // ----------------------------------------------------------------
  // decode and execute sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.decoded = 1'b0;
    state_next.decode_error = 1'b0;
    state_next.result_valid = 1'b0;
    unique case (state_reg.st)
      rotate_right_pkg::st_idle: begin
        if (byte_valid_i) begin
          if (byte_i == rotate_right_pkg::BIT_OP_PREFIX) begin
            state_next.st = rotate_right_pkg::st_bit_prefix; // RULE7
          end else if (is_index_prefix) begin
            state_next.st = rotate_right_pkg::st_index_prefix;
            state_next.idx_sel = byte_i[rotate_right_pkg::PREFIX_SEL_BIT];
          end else begin
            state_next.decode_error = 1'b1;
          end
        end
      end
      rotate_right_pkg::st_bit_prefix: begin
        if (byte_valid_i) begin
          if (is_rotate_byte) begin
            state_next.reg_sel = byte_i[rotate_right_pkg::REG_FIELD_HI:
                                        rotate_right_pkg::REG_FIELD_LO];
            if (byte_i[rotate_right_pkg::REG_FIELD_HI:
                       rotate_right_pkg::REG_FIELD_LO]
                == rotate_right_pkg::MEM_REG_SELECT) begin
              state_next.mode = rotate_right_pkg::indirect_register_mode;
              state_next.addr = pointer_register_pair_i; // RULE8
            end else begin
              state_next.mode = rotate_right_pkg::register_mode; // RULE7
              state_next.addr = rotate_right_pkg::ADDR_ZERO;
            end
            state_next.decoded = 1'b1;
            state_next.byte_ready = 1'b0;
            state_next.st = rotate_right_pkg::st_wait_operand;
          end else begin
            state_next.decode_error = 1'b1;
            state_next.st = rotate_right_pkg::st_idle;
          end
        end
      end
      rotate_right_pkg::st_index_prefix: begin
        if (byte_valid_i) begin
          if (byte_i == rotate_right_pkg::BIT_OP_PREFIX) begin
            state_next.st = rotate_right_pkg::st_index_bit_prefix;
          end else begin
            state_next.decode_error = 1'b1;
            state_next.st = rotate_right_pkg::st_idle;
          end
        end
      end
      rotate_right_pkg::st_index_bit_prefix: begin
        // displacement sits before the operation byte
        if (byte_valid_i) begin
          state_next.addr = index_base + disp_ext; // RULE10
          state_next.st = rotate_right_pkg::st_displacement;
        end
      end
      rotate_right_pkg::st_displacement: begin
        if (byte_valid_i) begin
          if (is_rotate_byte
              && byte_i[rotate_right_pkg::REG_FIELD_HI:
                        rotate_right_pkg::REG_FIELD_LO]
                 == rotate_right_pkg::MEM_REG_SELECT) begin
            state_next.mode = rotate_right_pkg::short_indexed_mode; // RULE10
            state_next.reg_sel = rotate_right_pkg::MEM_REG_SELECT;
            state_next.decoded = 1'b1;
            state_next.byte_ready = 1'b0;
            state_next.st = rotate_right_pkg::st_wait_operand;
          end else begin
            state_next.decode_error = 1'b1;
            state_next.st = rotate_right_pkg::st_idle;
          end
        end
      end
      rotate_right_pkg::st_wait_operand: begin
        // bytes are refused here so no decode overlaps an execution
        if (operand_valid_i) begin
          // result holds until the next operand, not only one cycle
          state_next.result = calc_result; // RULE1 RULE2
          state_next.flags = calc_flags; // RULE3 RULE4 RULE5 RULE6 RULE9
          state_next.result_valid = 1'b1;
          state_next.byte_ready = 1'b1;
          state_next.st = rotate_right_pkg::st_idle;
        end
      end
    endcase
    if (rst_i) begin
      state_next.st = rotate_right_pkg::st_idle;
      state_next.mode = rotate_right_pkg::register_mode;
      state_next.reg_sel = rotate_right_pkg::REG_ZERO;
      state_next.idx_sel = 1'b0;
      state_next.addr = rotate_right_pkg::ADDR_ZERO;
      state_next.byte_ready = 1'b1;
      state_next.decoded = 1'b0;
      state_next.decode_error = 1'b0;
      state_next.result_valid = 1'b0;
      state_next.result = rotate_right_pkg::BYTE_ZERO;
      state_next.flags = rotate_right_pkg::BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // no reset term here: rst_i already steers state_next
  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a bare flop of the record, no glue
  assign byte_ready_o = state_reg.byte_ready;
  assign decoded_o = state_reg.decoded;
  assign decode_error_o = state_reg.decode_error;
  assign mode_o = state_reg.mode;
  assign reg_select_o = state_reg.reg_sel;
  assign index_select_o = state_reg.idx_sel;
  assign operand_addr_o = state_reg.addr;
  assign result_valid_o = state_reg.result_valid;
  assign result_o = state_reg.result;
  assign flags_o = state_reg.flags;

endmodule

// [tb/rotate_right_carry_unit_sva.sv]
`timescale 1ns/100ps
module rotate_right_carry_unit_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] pointer_register_pair_i,
  input wire logic operand_valid_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] flags_i,
  input wire logic byte_ready_o,
  input wire logic decoded_o,
  input wire logic decode_error_o,
  input wire rotate_right_pkg::operand_mode_t mode_o,
  input wire logic [2:0] reg_select_o,
  input wire logic [15:0] operand_addr_o,
  input wire logic result_valid_o,
  input wire logic [7:0] result_o,
  input wire logic [7:0] flags_o
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_low_bits_shift: assert property (result_valid_o |->
    result_o[6:0] == $past(operand_i[7:1])) else $error("low bits wrong");
  a_carry_into_msb: assert property (result_valid_o |->
    result_o[7] == $past(flags_i[0])) else $error("msb not old carry");
  a_carry_out: assert property (result_valid_o |->
    flags_o[0] == $past(operand_i[0])) else $error("carry out wrong");
  a_sign_flag: assert property (result_valid_o |->
    flags_o[7] == result_o[7]) else $error("sign wrong");
  a_zero_flag: assert property (result_valid_o |->
    flags_o[6] == (result_o == 8'h00)) else $error("zero wrong");
  a_parity_flag: assert property (result_valid_o |->
    flags_o[2] == ~^result_o) else $error("parity wrong");
  a_half_sub_clear: assert property (result_valid_o |->
    !flags_o[4] && !flags_o[1]) else $error("half or sub set");
  a_operand_answer: assert property (operand_valid_i && !byte_ready_o
    |=> result_valid_o && byte_ready_o) else $error("no result");
  a_reg_form: assert property (decoded_o &&
    mode_o == rotate_right_pkg::register_mode |-> reg_select_o != 3'h6
    && !decode_error_o && !byte_ready_o) else $error("reg form bad");
  a_pointer_form: assert property (decoded_o &&
    mode_o == rotate_right_pkg::indirect_register_mode |->
    reg_select_o == 3'h6 && operand_addr_o == $past(pointer_register_pair_i))
    else $error("pointer form bad");
  a_index_form: assert property (decoded_o &&
    mode_o == rotate_right_pkg::short_indexed_mode |->
    reg_select_o == 3'h6 && !byte_ready_o) else $error("index form bad");
  c_reg: cover property (decoded_o && mode_o == 2'h0);
  c_pointer: cover property (decoded_o && mode_o == 2'h1);
  c_indexed: cover property (decoded_o && mode_o == 2'h2);
  c_error: cover property (decode_error_o);
endmodule

// [tb/rotate_right_carry_unit_bench.sv]
`timescale 1ns/100ps
module rotate_right_carry_unit_bench;
  logic clk_i, rst_i, byte_valid_i, operand_valid_i, byte_ready_o;
  logic decoded_o, decode_error_o, index_select_o, result_valid_o;
  logic [7:0] byte_i, operand_i, flags_i, result_o, flags_o;
  logic [15:0] pointer_register_pair_i, first_index_register_i;
  logic [15:0] second_index_register_i, operand_addr_o;
  logic [2:0] reg_select_o;
  rotate_right_pkg::operand_mode_t mode_o;
  logic [31:0] ra, rb;
  int n_errors, n_compared, seed, i;
  rotate_right_carry_unit u_rotate_right_carry_unit (.clk_i, .rst_i,
    .byte_valid_i, .byte_i, .pointer_register_pair_i,
    .first_index_register_i, .second_index_register_i, .operand_valid_i,
    .operand_i, .flags_i, .byte_ready_o, .decoded_o, .decode_error_o,
    .mode_o, .reg_select_o, .index_select_o, .operand_addr_o,
    .result_valid_o, .result_o, .flags_o);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [7:0] exp_res(input logic [7:0] o, input logic [7:0] f);
    return {f[0], o[7:1]};
  endfunction
  function logic [7:0] exp_flg(input logic [7:0] o, input logic [7:0] f);
    logic [7:0] q;
    q = exp_res(o, f);
    return {q[7], q == 8'h00, f[5], 1'b0, f[3], ~^q, 1'b0, o[0]};
  endfunction
  // valid stays up so bytes can run back to back
  task put(input logic [7:0] b);
    byte_valid_i = 1'b1;
    byte_i = b;
    @(posedge clk_i);
    #1;
  endtask
  task operand_step(input logic [7:0] o, input logic [7:0] f);
    operand_valid_i = 1'b1;
    operand_i = o;
    flags_i = f;
    @(posedge clk_i);
    #1;
    operand_valid_i = 1'b0;
    operand_i = 8'($random(seed));
    chk("result_valid", result_valid_o, 1'b1);
    chk("result", result_o, exp_res(o, f));
    chk("flags", flags_o, exp_flg(o, f));
    chk("ready", byte_ready_o, 1'b1);
  endtask
  task instr(input logic idx, input logic [2:0] rs, input logic xs,
             input logic [7:0] dd, input logic [7:0] o, input logic [7:0] f);
    logic [15:0] ea;
    pointer_register_pair_i = 16'($random(seed));
    if (idx) begin
      put({2'b11, xs, 5'h1d});
      put(8'hcb);
      put(dd);
      put(8'h1e);
      ea = (xs ? second_index_register_i : first_index_register_i)
           + {{8{dd[7]}}, dd};
    end else begin
      put(8'hcb);
      put({5'h03, rs});
      ea = (rs == 3'h6) ? pointer_register_pair_i : 16'h0000;
    end
    chk("decoded", decoded_o, 1'b1);
    chk("mode", mode_o, idx ? 16'h0002 : (rs == 3'h6 ? 16'h0001 : 16'h0000));
    chk("reg", reg_select_o, idx ? 3'h6 : rs);
    chk("addr", operand_addr_o, ea);
    if (idx) chk("index", index_select_o, xs);
    // a stray byte while waiting must be ignored
    put(8'($random(seed)));
    byte_valid_i = 1'b0;
    chk("wait", byte_ready_o | decoded_o | decode_error_o, 1'b0);
    operand_step(o, f);
  endtask
  task end_of_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial begin
    seed = 32'h281e_7800;
    n_errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    byte_valid_i = 1'b0;
    byte_i = 8'h00;
    operand_valid_i = 1'b0;
    operand_i = 8'h00;
    flags_i = 8'h00;
    pointer_register_pair_i = 16'h0000;
    first_index_register_i = 16'($random(seed));
    second_index_register_i = 16'($random(seed));
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("ready_rst", byte_ready_o, 1'b1);
    operand_valid_i = 1'b1;
    @(posedge clk_i);
    #1 operand_valid_i = 1'b0;
    chk("no_result", result_valid_o, 1'b0);
    instr(1'b0, 3'h0, 1'b0, 8'h00, 8'hdd, 8'h00);
    instr(1'b0, 3'h6, 1'b0, 8'h00, 8'h01, 8'h00);
    instr(1'b1, 3'h6, 1'b1, 8'h80, 8'h00, 8'hff);
    instr(1'b1, 3'h6, 1'b0, 8'h7f, 8'hfe, 8'h28);
    put(8'hcb);
    put(8'h20);
    chk("error_reg", decode_error_o, 1'b1);
    put(8'hfd);
    put(8'hcb);
    put(8'h05);
    put(8'h1f);
    chk("error_idx", decode_error_o, 1'b1);
    put(8'h00);
    chk("error_first", decode_error_o, 1'b1);
    put(8'hdd);
    put(8'h00);
    chk("error_no_cb", decode_error_o, 1'b1);
    for (i = 0; i < 60; i++) begin
      ra = $random(seed);
      rb = $random(seed);
      instr(ra[0], ra[3:1], ra[4], ra[15:8], ra[23:16], rb[7:0]);
    end
    // reset in mid-run while an operand is awaited
    put(8'hcb);
    put(8'h18);
    byte_valid_i = 1'b0;
    rst_i = 1'b1;
    operand_valid_i = 1'b1;
    @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("ready_mid_rst", byte_ready_o, 1'b1);
    chk("valid_mid_rst", result_valid_o, 1'b0);
    @(posedge clk_i);
    #1 operand_valid_i = 1'b0;
    chk("no_result_rst", result_valid_o, 1'b0);
    end_of_test;
  end
endmodule
bind rotate_right_carry_unit rotate_right_carry_unit_sva u_sva (.clk_i,
  .rst_i, .pointer_register_pair_i, .operand_valid_i, .operand_i, .flags_i,
  .byte_ready_o, .decoded_o, .decode_error_o, .mode_o, .reg_select_o,
  .operand_addr_o, .result_valid_o, .result_o, .flags_o);
